// >>> src/csr_pkg.sv
// Package for the CPU status and reset-cause flag block.
// Assumes a 25 MHz system clock and an Avalon-MM register bus.
package csr_pkg;

  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam logic [3:0] STATUS_IDX     = 4'h6;
  localparam logic [5:0] STATUS_ADDR    = 6'h18;
  localparam logic [5:0] IRQ_STAT_ADDR  = 6'h20;
  localparam logic [5:0] IRQ_EN_ADDR    = 6'h24;
  localparam logic [5:0] IRQ_CLR_ADDR   = 6'h28;
  localparam logic [5:0] SRC_EN_ADDR    = 6'h2C;

  // ==========================================================================
  // Status register bit positions
  localparam int BIT_BROWNOUT = 0;
  localparam int BIT_PWRON    = 1;
  localparam int BIT_SLEEP    = 2;
  localparam int BIT_WDOG     = 3;
  localparam int BIT_GMASK    = 4;
  localparam int BIT_STACK    = 5;
  localparam logic [7:0] STATUS_RESET = 8'h3D;
  localparam logic [7:0] STATUS_WMASK = 8'h13;

  // ==========================================================================
  // Stack pointer
  localparam logic [3:0] STACK_TOP = 4'hF;

  // ==========================================================================
  // Event interrupt bits
  localparam int EV_STACK_OVF = 0;
  localparam int EV_WDOG_TO   = 1;
  localparam int EV_SLEEP     = 2;
  localparam int EV_BROWNOUT  = 3;
  localparam int EV_W         = 4;

  // Device events from the core
  typedef struct packed {
    logic       pwr_on_rst;
    logic       brownout_rst;
    logic       master_rst;
    logic       wdog_rst;
    logic       watchdog_clear_op;
    logic       sleep_op;
    logic       wdog_timeout;
    logic       stack_valid;
    logic [3:0] stack_ptr;
  } csr_core_ev_t;

  // Bus fsm
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACK  = 3'b010,
    ST_DONE = 3'b100
  } csr_bus_st_t;

endpackage

// >>> src/csr_irq_gate.sv
// Interrupt gate: per-source enables combined under the global mask.
// Assumes enables and requests are synchronous to the system clock.
`timescale 1ns/1ps
module csr_irq_gate
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // Gating
  input  wire logic       gmask_i,
  input  wire logic [7:0] src_req_i,
  input  wire logic [7:0] src_en_i,
  // Result
  output logic [7:0]      irq_pass_o
);

  wire [7:0] pass_nxt;

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_src
      assign pass_nxt[g] = src_req_i[g] & src_en_i[g] & ~gmask_i;
    end
  endgenerate

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_pass_o <= 8'h00;
    else
      irq_pass_o <= pass_nxt;
  end

endmodule

// >>> src/csr_top.sv
// CPU status and reset-cause flag register with Avalon-MM access.
// Assumes core events are one-cycle pulses synchronous to clk_sys_i.
`timescale 1ns/1ps
module csr_top
(
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  // Avalon-MM slave
  input  wire logic [5:0]           avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [31:0]          avs_writedata_i,
  input  wire logic [3:0]           avs_byteenable_i,
  output logic [31:0]               avs_readdata_o,
  output logic                      avs_waitrequest_o,
  output logic [1:0]                avs_response_o,
  // Core events and configuration
  input  wire csr_pkg::csr_core_ev_t core_ev_i,
  input  wire logic                 brownout_detect_enable_i,
  input  wire logic [7:0]           irq_src_i,
  // Outputs
  output logic [7:0]                irq_pass_o,
  output logic                      global_irq_mask_o,
  output logic                      irq_o
);

  // ==========================================================================
  // Registers
  logic [7:0]            status_r;
  logic [7:0]            status_nxt;
  logic [7:0]            src_en_r;
  logic [csr_pkg::EV_W-1:0] ev_stat_r;
  logic [csr_pkg::EV_W-1:0] ev_en_r;
  csr_pkg::csr_bus_st_t  st_r;
  logic [3:0]            sp_prev_r;

  // ==========================================================================
  // Bus decode
  wire        req      = avs_read_i | avs_write_i;
  wire        take     = (st_r == csr_pkg::ST_ACK);
  wire        wr_take  = take & avs_write_i & avs_byteenable_i[0];
  wire        hit_stat = (avs_address_i == csr_pkg::STATUS_ADDR);
  wire        hit_ist  = (avs_address_i == csr_pkg::IRQ_STAT_ADDR);
  wire        hit_ien  = (avs_address_i == csr_pkg::IRQ_EN_ADDR);
  wire        hit_icl  = (avs_address_i == csr_pkg::IRQ_CLR_ADDR);
  wire        hit_sen  = (avs_address_i == csr_pkg::SRC_EN_ADDR);
  wire        mapped   = hit_stat | hit_ist | hit_ien | hit_icl | hit_sen;
  wire [7:0]  wdat     = avs_writedata_i[7:0];

  // ==========================================================================
  // Flag events
  wire ev_por   = core_ev_i.pwr_on_rst;
  wire ev_bor   = core_ev_i.brownout_rst & brownout_detect_enable_i;
  wire dev_rst  = ev_por | core_ev_i.brownout_rst | core_ev_i.master_rst
                  | core_ev_i.wdog_rst;
  wire sp_top   = core_ev_i.stack_valid & (core_ev_i.stack_ptr == csr_pkg::STACK_TOP);
  wire sp_wrap  = core_ev_i.stack_valid & (core_ev_i.stack_ptr == 4'h0)
                  & (sp_prev_r == csr_pkg::STACK_TOP);
  wire stk_ovf  = (sp_top | sp_wrap) & status_r[csr_pkg::BIT_STACK];
  wire [7:0] sw_val = (status_r & ~csr_pkg::STATUS_WMASK) | (wdat & csr_pkg::STATUS_WMASK);

  // Next status value, device logic wins over software
  always_comb
  begin
    status_nxt = status_r;
    if (wr_take && hit_stat)
      status_nxt = sw_val;
    if (core_ev_i.watchdog_clear_op)
    begin
      status_nxt[csr_pkg::BIT_WDOG]  = 1'b1;
      status_nxt[csr_pkg::BIT_SLEEP] = 1'b1;
    end
    if (core_ev_i.sleep_op)
    begin
      status_nxt[csr_pkg::BIT_WDOG]  = 1'b1;
      status_nxt[csr_pkg::BIT_SLEEP] = 1'b0;
    end
    if (core_ev_i.wdog_timeout)
      status_nxt[csr_pkg::BIT_WDOG] = 1'b0;
    if (sp_top | sp_wrap)
      status_nxt[csr_pkg::BIT_STACK] = 1'b0;
    if (dev_rst)
    begin
      status_nxt[csr_pkg::BIT_STACK] = 1'b1;
      status_nxt[csr_pkg::BIT_GMASK] = 1'b1;
    end
    if (ev_bor)
      status_nxt[csr_pkg::BIT_BROWNOUT] = 1'b0;
    if (ev_por)
      status_nxt = csr_pkg::STATUS_RESET;
    status_nxt[7:6] = 2'h0;
  end

  // ==========================================================================
  // Status flags
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      status_r <= csr_pkg::STATUS_RESET;
    else
      status_r <= status_nxt;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sp_prev_r <= 4'h0;
    else if (core_ev_i.stack_valid)
      sp_prev_r <= core_ev_i.stack_ptr;
  end

  // ==========================================================================
  // Event interrupt status, set wins over clear
  wire [csr_pkg::EV_W-1:0] ev_set;
  assign ev_set[csr_pkg::EV_STACK_OVF] = stk_ovf;
  assign ev_set[csr_pkg::EV_WDOG_TO]   = core_ev_i.wdog_timeout;
  assign ev_set[csr_pkg::EV_SLEEP]     = core_ev_i.sleep_op;
  assign ev_set[csr_pkg::EV_BROWNOUT]  = ev_bor;
  wire [csr_pkg::EV_W-1:0] ev_clr = (wr_take && hit_icl) ? wdat[csr_pkg::EV_W-1:0] : '0;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ev_stat_r <= '0;
    else
      ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ev_en_r <= '0;
    else if (wr_take && hit_ien)
      ev_en_r <= wdat[csr_pkg::EV_W-1:0];
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      src_en_r <= 8'h00;
    else if (wr_take && hit_sen)
      src_en_r <= wdat;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(ev_stat_r & ev_en_r);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      global_irq_mask_o <= 1'b1;
    else
      global_irq_mask_o <= status_nxt[csr_pkg::BIT_GMASK];
  end

  // ==========================================================================
  // Interrupt gating by global mask
  csr_irq_gate u_gate
  (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .gmask_i    (status_r[csr_pkg::BIT_GMASK]),
    .src_req_i  (irq_src_i),
    .src_en_i   (src_en_r),
    .irq_pass_o (irq_pass_o)
  );

  // ==========================================================================
  // Bus state machine: IDLE -> ACK (waitrequest low) -> DONE
  wire [31:0] rd_mux =
      hit_stat ? {24'h0, status_r} :
      hit_ist  ? {28'h0, ev_stat_r} :
      hit_ien  ? {28'h0, ev_en_r} :
      hit_sen  ? {24'h0, src_en_r} : 32'h0;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_r <= csr_pkg::ST_IDLE;
    else
    begin
      case (st_r)
        csr_pkg::ST_IDLE: st_r <= req ? csr_pkg::ST_ACK : csr_pkg::ST_IDLE;
        csr_pkg::ST_ACK:  st_r <= csr_pkg::ST_DONE;
        csr_pkg::ST_DONE: st_r <= csr_pkg::ST_IDLE;
        default:          st_r <= csr_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= ~((st_r == csr_pkg::ST_IDLE) & req);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      avs_readdata_o <= 32'h0;
      avs_response_o <= 2'h0;
    end
    else if ((st_r == csr_pkg::ST_IDLE) && req)
    begin
      avs_readdata_o <= avs_read_i ? rd_mux : 32'h0;
      avs_response_o <= mapped ? 2'h0 : 2'h3;
    end
  end

endmodule

// >>> test/csr_checker.sv
// Assertions on the ports of the status flag block.
// Assumes it is bound into csr_top and shares its single clock.
`timescale 1ns/1ps
module csr_checker
(
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  // Bus
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [1:0]  avs_response_o,
  // Interrupt gating
  input wire logic [7:0]  irq_src_i,
  input wire logic [7:0]  irq_pass_o,
  input wire logic        global_irq_mask_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire logic mapped = avs_address_i inside {6'h18, 6'h20, 6'h24, 6'h28, 6'h2C};
  // ==========================================================================
  // Bus steps and interrupt gating
  sequence s_ack;
    (avs_read_i || avs_write_i) && !avs_waitrequest_o;
  endsequence
  property p_wait_one; s_ack |=> avs_waitrequest_o; endproperty
  property p_answer; $rose(avs_read_i || avs_write_i) |-> ##[1:3] !avs_waitrequest_o; endproperty
  property p_unmapped; s_ack and !mapped |-> avs_response_o == 2'h3 && avs_readdata_o == 32'h0;
  endproperty
  property p_upper_zero; s_ack ##0 avs_read_i && avs_address_i == 6'h18
    |-> avs_readdata_o[31:6] == 26'h0; endproperty
  property p_stand; avs_waitrequest_o && $past(avs_waitrequest_o) |-> $stable(avs_readdata_o);
  endproperty
  property p_mask_blocks; $past(global_irq_mask_o) |-> irq_pass_o == 8'h00; endproperty
  property p_pass_subset; (irq_pass_o & ~$past(irq_src_i)) == 8'h00; endproperty
  property p_mask_fall; $fell(global_irq_mask_o) |-> $past(avs_write_i && !avs_waitrequest_o);
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  a_answer: assert property (p_answer) else $error("no bus answer");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");
  a_stand: assert property (p_stand) else $error("read data moved while idle");
  a_mask_blocks: assert property (p_mask_blocks) else $error("mask did not block");
  a_pass_subset: assert property (p_pass_subset) else $error("pass without request");
  a_mask_fall: assert property (p_mask_fall) else $error("mask cleared by device");
endmodule
bind csr_top csr_checker i_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .avs_response_o(avs_response_o), .irq_src_i(irq_src_i), .irq_pass_o(irq_pass_o),
  .global_irq_mask_o(global_irq_mask_o));

// >>> test/test_csr_top.sv
// Self-checking bench for the status flag block.
// Assumes csr_top with an Avalon-MM slave and one-cycle core event pulses.
`timescale 1ns/1ps
module test_csr_top;
  logic                  clk_sys_i, rst_n_i, avs_read_i, avs_write_i, bde, avs_waitrequest_o;
  logic                  global_irq_mask_o, irq_o;
  logic [5:0]            avs_address_i;
  logic [31:0]           avs_writedata_i, avs_readdata_o, q;
  logic [3:0]            avs_byteenable_i;
  logic [1:0]            avs_response_o, r;
  logic [7:0]            irq_src_i, irq_pass_o;
  csr_pkg::csr_core_ev_t core_ev_i;
  int                    mismatches = 0, samples_checked = 0, cycles = 0;
  csr_top i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .core_ev_i(core_ev_i), .brownout_detect_enable_i(bde), .irq_src_i(irq_src_i),
    .irq_pass_o(irq_pass_o), .global_irq_mask_o(global_irq_mask_o), .irq_o(irq_o));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude();
    end
  end
  // ==========================================================================
  // Tasks
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
    samples_checked++;
    if ((g & m) !== (e & m))
    begin
      mismatches++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e & m, g & m);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic acc(input logic wr, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_writedata_i <= {24'h0, d};
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    r = avs_response_o;
    if (n >= 50)
      mismatches++;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
    acc(1'b0, a, 8'h00);
    chk({24'h0, e}, q, {24'hFFFFFF, m});
    chk(32'h0, {30'h0, r}, 32'h3);
  endtask
  task automatic ev(input logic [11:0] v);
    @(posedge clk_sys_i);
    core_ev_i <= v;
    @(posedge clk_sys_i);
    core_ev_i <= '0;
  endtask
  task automatic late(input logic [7:0] e, input logic [7:0] g);
    chk({24'h0, e}, {24'h0, g}, 32'hFF);
  endtask
  // ==========================================================================
  // Tests
  initial
  begin
    rst_n_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 6'h00;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    bde = 1'b1;
    core_ev_i = '0;
    irq_src_i = 8'h81;
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rdc(6'h18, 8'h3D, 8'hFF);
    acc(1'b0, 6'h04, 8'h00);
    chk(32'h3, {30'h0, r}, 32'h3);
    acc(1'b1, 6'h18, 8'hFF);
    rdc(6'h18, 8'h3F, 8'hFF);
    acc(1'b1, 6'h18, 8'h00);
    rdc(6'h18, 8'h2C, 8'hFF);
    ev(12'h040);
    rdc(6'h18, 8'h28, 8'hFF);
    ev(12'h020);
    rdc(6'h18, 8'h20, 8'hFF);
    ev(12'h040);
    rdc(6'h18, 8'h28, 8'hFF);
    ev(12'h080);
    rdc(6'h18, 8'h2C, 8'hFF);
    $display("test flags done");
    ev(12'h01E);
    rdc(6'h18, 8'h2C, 8'hFF);
    ev(12'h01F);
    rdc(6'h18, 8'h0C, 8'hFF);
    ev(12'h013);
    acc(1'b1, 6'h18, 8'hFF);
    rdc(6'h18, 8'h1F, 8'hFF);
    ev(12'h200);
    rdc(6'h18, 8'h33, 8'h33);
    ev(12'h100);
    rdc(6'h18, 8'h02, 8'h02);
    ev(12'h400);
    rdc(6'h18, 8'h02, 8'h03);
    ev(12'h800);
    rdc(6'h18, 8'h3D, 8'hFF);
    acc(1'b1, 6'h18, 8'h13);
    rdc(6'h18, 8'h3F, 8'hFF);
    bde <= 1'b0;
    ev(12'h400);
    bde <= 1'b1;
    $display("test resets done");
    acc(1'b1, 6'h28, 8'h0F);
    rdc(6'h20, 8'h00, 8'h0F);
    ev(12'h020);
    rdc(6'h20, 8'h02, 8'h0F);
    late(8'h00, {7'h0, irq_o});
    acc(1'b1, 6'h24, 8'h02);
    rdc(6'h24, 8'h02, 8'h0F);
    late(8'h01, {7'h0, irq_o});
    acc(1'b1, 6'h28, 8'h02);
    rdc(6'h20, 8'h00, 8'h0F);
    late(8'h00, {7'h0, irq_o});
    acc(1'b1, 6'h2C, 8'h01);
    rdc(6'h2C, 8'h01, 8'hFF);
    late(8'h00, irq_pass_o);
    acc(1'b1, 6'h18, 8'h03);
    rdc(6'h18, 8'h27, 8'h3F);
    late(8'h00, {7'h0, global_irq_mask_o});
    late(8'h01, irq_pass_o);
    irq_src_i <= 8'h80;
    repeat (3) @(posedge clk_sys_i);
    late(8'h00, irq_pass_o);
    $display("test interrupts done");
    conclude();
  end
endmodule
